// ==== hdl/rxgc_regs.sv ====
// Receive gain control and override register bank with the gain loop.
// Assumes a host write/read port already decoded from the serial port.
// What this block does
// - OR override mask register at 0x22, 16 bits, resets to zero.
// - Bit 15 overrides detector reset, active low resets peak detectors.
// - Bit 13 overrides output switch bias select, one means external bias.
// - Bit 12 overrides buffer path: zero oscillator buffers, one amplifier.
// - Bits 14,11,8..0 override one-hot power-downs, one powers down.
// - Both transmit amplifier power-downs set together also power down up-mixers.
// - Manual enable applies stored manual gain during reception.
// - Gain field resets 0x7F; write stores manual, read gives gain used.
// - Forced mode: zero loop, one low, two medium, three high.
// - Read-only bits report front-end gain mode in effect.
// - Hysteresis, reset 3, applied to mode switching.
// - Upper threshold, reset 25, switches medium and high mode.
// - Lower threshold, reset 9, switches low and medium mode.
// - Loop mode: blank select zero blanks on stage removal, one never.
// - Manual mode: blanking only when blank select is one.
// - Current boost bit doubles peak detector bias current.
// - Settle delay field sets wait after a gain change.
// - Detector enable mask selects detectors used by the loop.
// - Window length codes select 8, 16, 32 or 64 samples.
// - Target field, reset 20, sets loop regulation level.
// - Used signal is raw AND and-mask, then OR or-mask.
// - AND mask comes in from its own register bank, which resets it to all ones.
`timescale 1ns/1ns
module rxgc_regs (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] and_mask_register,
  input wire logic [15:0] raw_signals,
  input wire logic rx_active,
  input wire logic sample_en,
  input wire logic [2:0] det_valid,
  input wire logic [5:0] det_level,
  output logic [15:0] used_signals,
  output logic upmixer_powerdown,
  output logic [6:0] vga_gain,
  output logic [1:0] frontend_gain_mode,
  output logic vga_blank,
  output logic detector_current_boost
);
  logic [15:0] or_mask_ff;
  logic [15:0] ctrl_ff;
  logic [15:0] thr_ff;
  logic [15:0] tune_ff;
  rxgc_ctl_if ctl ();
  wire wr_or = reg_wr && reg_addr == rxgc_pkg::ADDR_OR_MASK;
  wire wr_ctrl = reg_wr && reg_addr == rxgc_pkg::ADDR_LOOP_CTRL;
  wire wr_thr = reg_wr && reg_addr == rxgc_pkg::ADDR_THRESH;
  wire wr_tune = reg_wr && reg_addr == rxgc_pkg::ADDR_TUNING;
  // Reserved bits are masked so a careless host cannot disturb the loop
  wire [15:0] ctrl_w = reg_wdata & rxgc_pkg::LOOP_CTRL_WMASK;
  wire [15:0] tune_w = reg_wdata & rxgc_pkg::TUNING_WMASK;
  wire [15:0] ctrl_rd = {4'h0, ctrl_ff[rxgc_pkg::B_MAN_GAIN_EN], ctl.gain_used,
    ctrl_ff[rxgc_pkg::FMODE_HI:rxgc_pkg::FMODE_LO], ctl.mode_used};
  wire [15:0] rd_mux = (reg_addr == rxgc_pkg::ADDR_OR_MASK) ? or_mask_ff
    : (reg_addr == rxgc_pkg::ADDR_LOOP_CTRL) ? ctrl_rd
    : (reg_addr == rxgc_pkg::ADDR_THRESH) ? thr_ff
    : (reg_addr == rxgc_pkg::ADDR_TUNING) ? tune_ff : 16'h0000;
  // The external and-mask is driven by its own bank; it resets to all ones there
  wire [15:0] used_nxt = (raw_signals & and_mask_register) | or_mask_ff;
  wire upmix_nxt = used_nxt[rxgc_pkg::B_TXAMP_NEG_PD] &&
    used_nxt[rxgc_pkg::B_TXAMP_POS_PD];
  assign ctl.man_en = ctrl_ff[rxgc_pkg::B_MAN_GAIN_EN];
  assign ctl.man_gain = ctrl_ff[rxgc_pkg::GAIN_HI:rxgc_pkg::GAIN_LO];
  assign ctl.forced_mode = ctrl_ff[rxgc_pkg::FMODE_HI:rxgc_pkg::FMODE_LO];
  assign ctl.hyst = thr_ff[rxgc_pkg::HYST_HI:rxgc_pkg::HYST_LO];
  assign ctl.thr_h = thr_ff[rxgc_pkg::THR_H_HI:rxgc_pkg::THR_H_LO];
  assign ctl.thr_l = thr_ff[rxgc_pkg::THR_L_HI:rxgc_pkg::THR_L_LO];
  assign ctl.blank_sel = tune_ff[rxgc_pkg::B_BLANK_SEL];
  assign ctl.settle = tune_ff[rxgc_pkg::SETTLE_HI:rxgc_pkg::SETTLE_LO];
  assign ctl.det_en = tune_ff[rxgc_pkg::DETEN_HI:rxgc_pkg::DETEN_LO];
  assign ctl.win = tune_ff[rxgc_pkg::WIN_HI:rxgc_pkg::WIN_LO];
  assign ctl.target = tune_ff[rxgc_pkg::TARGET_HI:rxgc_pkg::TARGET_LO];
  rxgc_loop u_loop (
    .clock(clock),
    .reset_n(reset_n),
    .rx_active(rx_active),
    .sample_en(sample_en),
    .det_valid(det_valid),
    .det_level(det_level),
    .ctl(ctl)
  );
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      or_mask_ff <= rxgc_pkg::OR_MASK_RESET;
      ctrl_ff <= rxgc_pkg::LOOP_CTRL_RESET;
      thr_ff <= rxgc_pkg::THRESH_RESET;
      tune_ff <= rxgc_pkg::TUNING_RESET;
    end
    else
    begin
      if (wr_or)
        or_mask_ff <= reg_wdata;
      if (wr_ctrl)
        ctrl_ff <= ctrl_w;
      if (wr_thr)
        thr_ff <= reg_wdata;
      if (wr_tune)
        tune_ff <= tune_w;
    end
  end
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_rdata <= 16'h0000;
      used_signals <= 16'h0000;
      upmixer_powerdown <= 1'b0;
      vga_gain <= rxgc_pkg::GAIN_MAX;
      frontend_gain_mode <= rxgc_pkg::MODE_LOOP;
      vga_blank <= 1'b0;
      detector_current_boost <= 1'b0;
    end
    else
    begin
      if (reg_rd)
        reg_rdata <= rd_mux;
      // One register stage keeps all outputs glitch free; writes show next cycle
      used_signals <= used_nxt;
      upmixer_powerdown <= upmix_nxt;
      vga_gain <= ctl.gain_used;
      frontend_gain_mode <= ctl.mode_used;
      vga_blank <= ctl.blank;
      detector_current_boost <= tune_ff[rxgc_pkg::B_DET_BOOST];
    end
  end
endmodule // rxgc_regs

// ==== shared/rxgc_pkg.sv ====
// Package for the receive gain control and override register bank.
// Assumes a 16-bit register port with 6-bit addresses, single clock.
package rxgc_pkg;
  localparam logic [5:0] ADDR_OR_MASK = 6'h22;
  localparam logic [5:0] ADDR_LOOP_CTRL = 6'h23;
  localparam logic [5:0] ADDR_THRESH = 6'h24;
  localparam logic [5:0] ADDR_TUNING = 6'h25;
  localparam logic [15:0] OR_MASK_RESET = 16'h0000;
  localparam logic [15:0] AND_MASK_RESET = 16'hFFFF;
  localparam logic [15:0] LOOP_CTRL_RESET = 16'h07F0;
  localparam logic [15:0] THRESH_RESET = 16'h3649;
  localparam logic [15:0] TUNING_RESET = 16'h0854;
  localparam logic [15:0] LOOP_CTRL_WMASK = 16'h0FFC;
  localparam logic [15:0] TUNING_WMASK = 16'h7FFF;
  localparam int B_DET_RESET_N = 15;
  localparam int B_GLOBAL_BIAS_POWERDOWN = 14;
  localparam int B_SWITCH_BIAS = 13;
  localparam int B_PATH_SEL = 12;
  localparam int B_TXAMP_NEG_PD = 10;
  localparam int B_TXAMP_POS_PD = 9;
  localparam int B_MAN_GAIN_EN = 11;
  localparam int GAIN_HI = 10;
  localparam int GAIN_LO = 4;
  localparam int FMODE_HI = 3;
  localparam int FMODE_LO = 2;
  localparam int HYST_HI = 15;
  localparam int HYST_LO = 12;
  localparam int THR_H_HI = 11;
  localparam int THR_H_LO = 6;
  localparam int THR_L_HI = 5;
  localparam int THR_L_LO = 0;
  localparam int B_BLANK_SEL = 14;
  localparam int B_DET_BOOST = 13;
  localparam int SETTLE_HI = 12;
  localparam int SETTLE_LO = 11;
  localparam int DETEN_HI = 10;
  localparam int DETEN_LO = 8;
  localparam int WIN_HI = 7;
  localparam int WIN_LO = 6;
  localparam int TARGET_HI = 5;
  localparam int TARGET_LO = 0;
  localparam logic [1:0] MODE_LOOP = 2'h0;
  localparam logic [1:0] MODE_LOW = 2'h1;
  localparam logic [1:0] MODE_MED = 2'h2;
  localparam logic [1:0] MODE_HIGH = 2'h3;
  localparam logic [6:0] GAIN_MAX = 7'h7F;
  localparam logic [6:0] GAIN_STAGE = 7'h07;
  localparam logic [3:0] WIN_BASE_LOG2 = 4'h3;
  localparam logic [3:0] SETTLE_BASE = 4'h4;
endpackage

// ==== shared/rxgc_ctl_if.sv ====
// Carrier of loop settings from the register bank to the gain loop.
// Assumes both ends share the device clock.
`timescale 1ns/1ns
interface rxgc_ctl_if;
  logic man_en;
  logic [6:0] man_gain;
  logic [1:0] forced_mode;
  logic [3:0] hyst;
  logic [5:0] thr_h;
  logic [5:0] thr_l;
  logic blank_sel;
  logic [1:0] settle;
  logic [2:0] det_en;
  logic [1:0] win;
  logic [5:0] target;
  logic [6:0] gain_used;
  logic [1:0] mode_used;
  logic blank;
  modport regs (output man_en, man_gain, forced_mode, hyst, thr_h, thr_l, blank_sel,
    settle, det_en, win, target, input gain_used, mode_used, blank);
  modport loop (input man_en, man_gain, forced_mode, hyst, thr_h, thr_l, blank_sel,
    settle, det_en, win, target, output gain_used, mode_used, blank);
endinterface

// ==== hdl/rxgc_loop.sv ====
// Gain loop: accumulate-and-dump over a window, steps gain and front-end mode.
// Assumes detector magnitudes in 2 dB units arriving with a sample strobe.
`timescale 1ns/1ns
module rxgc_loop (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic rx_active,
  input wire logic sample_en,
  input wire logic [2:0] det_valid,
  input wire logic [5:0] det_level,
  rxgc_ctl_if.loop ctl
);
  logic [11:0] acc_ff;
  logic [6:0] cnt_ff;
  logic [3:0] settle_ff;
  logic [6:0] gain_ff;
  logic [1:0] mode_ff;
  logic blank_ff;
  wire [3:0] win_log2 = rxgc_pkg::WIN_BASE_LOG2 + {2'h0, ctl.win};
  wire [6:0] win_last = 7'((8'h01 << win_log2) - 8'h01);
  wire use_sample = sample_en && rx_active && |(det_valid & ctl.det_en);
  // Shrinking the window mid-count dumps at once instead of wrapping the counter
  wire dump = use_sample && (cnt_ff >= win_last);
  wire [11:0] acc_sum = acc_ff + {6'h00, det_level};
  wire [5:0] avg = 6'(acc_sum >> win_log2);
  // High/medium moves use the upper threshold, medium/low moves the lower one
  wire [5:0] down_ref = (mode_ff == rxgc_pkg::MODE_HIGH) ? ctl.thr_h : ctl.thr_l;
  wire [5:0] up_ref = (mode_ff == rxgc_pkg::MODE_MED) ? ctl.thr_h : ctl.thr_l;
  wire [6:0] down_thr = {1'b0, down_ref} + {3'h0, ctl.hyst};
  wire [6:0] avg_hyst = {1'b0, avg} + {3'h0, ctl.hyst};
  wire too_big = avg > ctl.target;
  wire too_small = avg < ctl.target;
  wire step_down = too_big && gain_ff >= rxgc_pkg::GAIN_STAGE;
  wire blank_ok = ctl.man_en ? ctl.blank_sel : !ctl.blank_sel;
  wire act = dump && settle_ff == 4'h0;
  logic [1:0] nxt_mode;
  always_comb
  begin
    nxt_mode = mode_ff;
    if ({1'b0, avg} > down_thr && mode_ff != rxgc_pkg::MODE_LOW)
      nxt_mode = mode_ff - 2'h1;
    else if (avg_hyst < {1'b0, up_ref} && mode_ff != rxgc_pkg::MODE_HIGH)
      nxt_mode = mode_ff + 2'h1;
  end
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_ff <= 12'h000;
      cnt_ff <= 7'h00;
      settle_ff <= 4'h0;
      gain_ff <= rxgc_pkg::GAIN_MAX;
      mode_ff <= rxgc_pkg::MODE_HIGH;
      blank_ff <= 1'b0;
    end
    else
    begin
      blank_ff <= 1'b0;
      if (dump && settle_ff != 4'h0)
        settle_ff <= settle_ff - 4'h1;
      if (use_sample)
      begin
        acc_ff <= dump ? 12'h000 : acc_sum;
        cnt_ff <= dump ? 7'h00 : cnt_ff + 7'h01;
      end
      if (act)
      begin
        mode_ff <= nxt_mode;
        if (step_down)
        begin
          gain_ff <= gain_ff - rxgc_pkg::GAIN_STAGE;
          blank_ff <= blank_ok;
        end
        else if (too_small && gain_ff <= rxgc_pkg::GAIN_MAX - rxgc_pkg::GAIN_STAGE)
          gain_ff <= gain_ff + rxgc_pkg::GAIN_STAGE;
        if (too_big || too_small || nxt_mode != mode_ff)
          settle_ff <= rxgc_pkg::SETTLE_BASE * {2'h0, ctl.settle};
      end
      else if (ctl.man_en && blank_ok && !rx_active)
        blank_ff <= 1'b0;
    end
  end
  assign ctl.gain_used = (ctl.man_en && rx_active) ? ctl.man_gain : gain_ff;
  assign ctl.mode_used = (ctl.forced_mode == rxgc_pkg::MODE_LOOP) ? mode_ff
    : ctl.forced_mode;
  assign ctl.blank = blank_ff || (ctl.man_en && ctl.blank_sel && rx_active);
endmodule // rxgc_loop

// ==== tb/rxgc_regs_chk_sva.sv ====
// Checker for the gain control register bank, watching top ports only.
// Assumes one-cycle host strobes and a single clock domain.
`timescale 1ns/1ns
module rxgc_regs_chk (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic [15:0] and_mask_register,
  input wire logic [15:0] raw_signals,
  input wire logic [15:0] used_signals,
  input wire logic upmixer_powerdown,
  input wire logic [1:0] frontend_gain_mode,
  input wire logic detector_current_boost
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // A lone write: no second write to the same place in the next cycle
  sequence s_wr(logic [5:0] a);
    reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a);
  endsequence
  sequence s_rd(logic [5:0] a);
    reg_rd && reg_addr == a && !reg_wr;
  endsequence
  property p_or_used;
    s_wr(rxgc_pkg::ADDR_OR_MASK) |=> used_signals ==
      (($past(raw_signals) & $past(and_mask_register)) | $past(reg_wdata, 2));
  endproperty
  a_or_used: assert property (p_or_used) else $error("used signals wrong");
  property p_upmix;
    upmixer_powerdown == (used_signals[10] & used_signals[9]);
  endproperty
  a_upmix: assert property (p_upmix) else $error("upmixer wrong");
  property p_rd_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
  property p_unmapped;
    reg_rd && (reg_addr < 6'h22 || reg_addr > 6'h25) |=> reg_rdata == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_or_rb;
    s_wr(rxgc_pkg::ADDR_OR_MASK) ##1 s_rd(rxgc_pkg::ADDR_OR_MASK)
      |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_or_rb: assert property (p_or_rb) else $error("or mask readback");
  property p_thr_rb;
    s_wr(rxgc_pkg::ADDR_THRESH) ##1 s_rd(rxgc_pkg::ADDR_THRESH)
      |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_thr_rb: assert property (p_thr_rb) else $error("threshold readback");
  property p_ctl_rsv;
    s_wr(rxgc_pkg::ADDR_LOOP_CTRL) ##1 s_rd(rxgc_pkg::ADDR_LOOP_CTRL)
      |=> reg_rdata[15:12] == 4'h0 && reg_rdata[11] == $past(reg_wdata[11], 3);
  endproperty
  a_ctl_rsv: assert property (p_ctl_rsv) else $error("control readback");
  property p_boost;
    s_wr(rxgc_pkg::ADDR_TUNING) |=> detector_current_boost == $past(reg_wdata[13], 2);
  endproperty
  a_boost: assert property (p_boost) else $error("boost wrong");
  property p_fmode;
    s_wr(rxgc_pkg::ADDR_LOOP_CTRL) ##0 $past(reg_wdata[3:2]) != 2'h0
      |=> frontend_gain_mode == $past(reg_wdata[3:2], 2);
  endproperty
  a_fmode: assert property (p_fmode) else $error("forced mode wrong");
endmodule // rxgc_regs_chk
bind rxgc_regs rxgc_regs_chk u_rxgc_regs_chk (.*);

// ==== tb/rxgc_host.sv ====
// Host model: issues single-word writes and reads to the register bank.
// Assumes the bank takes strobes on the rising edge, read data a cycle later.
`timescale 1ns/1ns
module rxgc_host (
  input wire logic clock,
  output logic reg_wr,
  output logic reg_rd,
  output logic [5:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h3F;
    reg_wdata = 16'h0000;
  end
  // Callers keep reserved bits zero, except where the bench breaks it on purpose
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
    // Released data is scrambled so a bank latching late cannot pass
    reg_wdata <= ~v;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] v);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
endmodule // rxgc_host

// ==== tb/tb_top.sv ====
// Bench for the gain control register bank, driven through a host model.
// Assumes the bank's outputs settle two edges after a write.
`timescale 1ns/1ns
module tb_top;
  logic clock, reset_n, reg_wr, reg_rd, rx_active, sample_en;
  logic upmixer_powerdown, vga_blank, detector_current_boost;
  logic [5:0] reg_addr, det_level;
  logic [15:0] reg_wdata, reg_rdata, and_mask_register, raw_signals, used_signals, d;
  logic [2:0] det_valid;
  logic [6:0] vga_gain;
  logic [1:0] frontend_gain_mode;
  int errors = 0;
  int n_checks = 0;
  int blanks = 0;
  int nb = 0;
  rxgc_regs u_rxgc_regs (.*);
  rxgc_host u_rxgc_host (.*);
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Blanking pulses last one cycle, so they are counted rather than polled
  always @(posedge clock)
  begin
    if (vga_blank === 1'b1)
      blanks <= blanks + 1;
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rc(input logic [5:0] a, input logic [15:0] e);
    u_rxgc_host.rd(a, d);
    chk("rdata", d, e);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clock);
    errors++;
    summarize();
  end
  initial
  begin
    reset_n = 1'b0;
    and_mask_register = 16'hFFFF;
    raw_signals = 16'hA5C3;
    rx_active = 1'b0;
    sample_en = 1'b0;
    det_valid = 3'h0;
    det_level = 6'h00;
    repeat (5) @(posedge clock);
    reset_n <= 1'b1;
    rc(6'h22, 16'h0000);
    rc(6'h23, 16'h07F3);
    rc(6'h24, 16'h3649);
    rc(6'h25, 16'h0854);
    u_rxgc_host.wr(6'h24, 16'h2A87);
    rc(6'h24, 16'h2A87);
    u_rxgc_host.wr(6'h24, 16'h3649);
    chk("used", used_signals, 16'hA5C3);
    @(posedge clock);
    and_mask_register <= 16'h0FF0;
    settle(3);
    chk("used", used_signals, 16'h05C0);
    @(posedge clock);
    and_mask_register <= 16'hFFFF;
    raw_signals <= 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      u_rxgc_host.wr(6'h22, 16'h0001 << i);
      settle(2);
      chk("used", used_signals, 16'h0001 << i);
      chk("upmix", {15'h0000, upmixer_powerdown}, 16'h0000);
    end
    u_rxgc_host.wr(6'h22, 16'h4000);
    rc(6'h22, 16'h4000);
    u_rxgc_host.wr(6'h22, 16'h0600);
    settle(2);
    chk("upmix", {15'h0000, upmixer_powerdown}, 16'h0001);
    u_rxgc_host.wr(6'h26, 16'hFFFF);
    rc(6'h21, 16'h0000);
    rc(6'h26, 16'h0000);
    rc(6'h22, 16'h0600);
    @(posedge clock);
    rx_active <= 1'b1;
    u_rxgc_host.wr(6'h23, 16'hF9A8);
    settle(3);
    chk("gain", {9'h000, vga_gain}, 16'h001A);
    rc(6'h23, 16'h09AA);
    for (int m = 1; m < 4; m++)
    begin
      u_rxgc_host.wr(6'h23, 16'h0800 | (m << 2));
      settle(3);
      chk("mode", {14'h0000, frontend_gain_mode}, m[15:0]);
    end
    u_rxgc_host.wr(6'h23, 16'hFA58);
    rc(6'h23, 16'h0A5A);
    u_rxgc_host.wr(6'h25, 16'hFFFF);
    settle(2);
    chk("boost", {15'h0000, detector_current_boost}, 16'h0001);
    rc(6'h25, 16'h7FFF);
    u_rxgc_host.wr(6'h23, 16'h07F0);
    u_rxgc_host.wr(6'h25, 16'h4014);
    settle(2);
    chk("boost", {15'h0000, detector_current_boost}, 16'h0000);
    @(posedge clock);
    sample_en <= 1'b1;
    det_valid <= 3'h7;
    det_level <= 6'h3F;
    settle(100);
    // With every detector masked the loop must not move
    chk("gain_idle", {9'h000, vga_gain}, 16'h007F);
    chk("mode_idle", {14'h0000, frontend_gain_mode}, 16'h0003);
    nb = blanks;
    u_rxgc_host.wr(6'h25, 16'h4754);
    settle(400);
    // A strong input walks the gain down in whole stages and the mode to low
    chk("gain_cut", {9'h000, vga_gain}, 16'h0001);
    chk("mode_low", {14'h0000, frontend_gain_mode}, 16'h0001);
    rc(6'h23, 16'h0011);
    @(posedge clock);
    det_level <= 6'h00;
    settle(500);
    chk("gain_up", {9'h000, vga_gain}, 16'h007F);
    chk("mode_high", {14'h0000, frontend_gain_mode}, 16'h0003);
    rc(6'h23, 16'h07F3);
    chk("no_blank", 16'(blanks - nb), 16'h0000);
    nb = blanks;
    u_rxgc_host.wr(6'h25, 16'h0714);
    @(posedge clock);
    det_level <= 6'h3F;
    settle(400);
    // Eighteen stage cuts from full gain, each one blanked
    chk("blanks", 16'(blanks - nb), 16'h0012);
    u_rxgc_host.wr(6'h25, 16'h0F14);
    @(posedge clock);
    det_level <= 6'h00;
    settle(400);
    // A settle wait stretches the climb past this span
    chk("settle", {15'h0000, vga_gain < 7'h7F}, 16'h0001);
    u_rxgc_host.wr(6'h23, 16'h0A50);
    settle(3);
    chk("man_gain", {9'h000, vga_gain}, 16'h0025);
    chk("blank_man0", {15'h0000, vga_blank}, 16'h0000);
    u_rxgc_host.wr(6'h25, 16'h4F14);
    settle(2);
    chk("blank_man1", {15'h0000, vga_blank}, 16'h0001);
    summarize();
  end
endmodule // tb_top
